// >>> design/hpa_pkg.sv
package hpa_pkg;
    // =========================================
    // widths
    localparam int NUM_AGC = 6;
    localparam int AW      = 8;
    localparam int DW      = 16;
    localparam int SW      = 12;
    // =========================================
    // device register map
    localparam logic [7:0] OFS_AGC_I  = 8'h00;
    localparam logic [7:0] OFS_AGC_Q  = 8'h06;
    localparam logic [7:0] OFS_SIG    = 8'h0C;
    localparam logic [7:0] OFS_CLK    = 8'h20;
    localparam logic [7:0] OFS_STAT   = 8'h21;
    localparam logic [7:0] OFS_FIR    = 8'h22;
    localparam logic [7:0] OFS_CSTART = 8'h23;
    localparam logic [7:0] OFS_CSTOP  = 8'h24;
    localparam logic [7:0] OFS_CDATA  = 8'h25;
    localparam logic [7:0] OFS_OCFG   = 8'h68;
    localparam logic [7:0] OFS_OBUD   = 8'h69;
    localparam logic [7:0] GUARD_LO   = 8'h68;
    localparam logic [7:0] GUARD_HI   = 8'hE7;
    // =========================================
    // output port budget
    localparam logic [3:0] FRAME_OVH   = 4'h1;
    localparam logic [3:0] CYC_IQG_IL  = 4'h3;
    localparam logic [3:0] CYC_IQG_PAR = 4'h2;
    localparam logic [3:0] CYC_IQ_IL   = 4'h2;
    localparam logic [3:0] CYC_IQ_PAR  = 4'h1;
    // =========================================
    // timing
    localparam int CLK_MHZ      = 200;
    localparam int RST_NS       = 30;
    localparam int RST_CYC      = (RST_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_US    = 200;
    localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;
    localparam int HCLK_MAX_MHZ = 100;
    localparam int HCLK_DIV_MIN = CLK_MHZ / HCLK_MAX_MHZ + 1;
    localparam int ACC_WAIT     = 2;
    // =========================================
    // host register map and fields
    localparam logic [2:0] H_ADDR  = 3'h0;
    localparam logic [2:0] H_WDATA = 3'h1;
    localparam logic [2:0] H_GO    = 3'h2;
    localparam logic [2:0] H_STAT  = 3'h3;
    localparam logic [2:0] H_RDATA = 3'h4;
    localparam logic [2:0] H_MODE  = 3'h5;
    localparam int GO_RD     = 0;
    localparam int GO_SER    = 1;
    localparam int MODE_DS   = 0;
    localparam int MODE_BYTE = 1;

    // five bits: six channels at three cycles plus overhead reach 19
    function automatic logic [4:0] frame_budget(input logic [7:0] cfg);
        logic [3:0] per;
        logic [4:0] sum;
        per = (cfg[7:6] == 2'h0) ? CYC_IQG_IL  :
              (cfg[7:6] == 2'h1) ? CYC_IQG_PAR :
              (cfg[7:6] == 2'h2) ? CYC_IQ_IL   : CYC_IQ_PAR;
        sum = 5'(FRAME_OVH);
        for (int k = 0; k < NUM_AGC; k++) begin
            if (cfg[k]) sum = sum + 5'(per);
        end
        return sum;
    endfunction : frame_budget
endpackage : hpa_pkg

// >>> design/hpa_if.sv
`timescale 1ns/100ps
interface hpa_if;
    logic        rst_n;
    logic        hclk;
    logic        style_ds;
    logic        byte_mode;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  addr;
    logic [15:0] h_dout;
    logic        h_doe_n;
    logic [15:0] d_dout;
    logic        d_doe_n;
    logic        ack_o;
    logic        ack_oe_n;
    logic        serial_select_n;
    logic        sdi;
    // =========================================
    // wire resolution, ack pin pulled up
    wire  [15:0] data = !d_doe_n ? d_dout : (!h_doe_n ? h_dout : 16'h0000);
    wire         ack  = ack_oe_n | ack_o;

    modport device (input rst_n, hclk, style_ds, byte_mode, cs_n, rd_n, wr_n, addr,
                     data, serial_select_n, sdi,
                     output d_dout, d_doe_n, ack_o, ack_oe_n);
    modport host (output rst_n, hclk, style_ds, byte_mode, cs_n, rd_n, wr_n, addr,
                   h_dout, h_doe_n, serial_select_n, sdi,
                   input data, ack);
endinterface : hpa_if

// >>> design/hpa_dev.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - six read-only in-phase results, bypass included
// - six read-only quadrature results, bypass included
// - strength result updates only while stage enabled
// - all sample data two's complement
// - core clock off until clock programmed
// - host waits settle before guarded range
// - host pulses reset low at least 30 ns
// - host supplies port clock, not above core
// - port clock strictly below 100 MHz
// - 16-bit bus, byte mode ignores upper lanes
// - one overhead cycle per output frame
// - per-channel cycles three, two, two, one
// - a channel's words stay on one port
// - filters off, coefficient reads invalid
// - strobe style pending low until done
// - strobe-data style acknowledges with low
// - host holds strobes until completion shown
// - held select starts next access, next address
// - host uses equal coefficient start and stop; the testbench also runs a two-word window, start 2 and stop 3
// - host releases serial select after each byte
module hpa_dev #(
    parameter int SETTLE_CYCLES = hpa_pkg::SETTLE_CYC,
    parameter int COEF_DEPTH    = 16
) (
    // clock and reset
    input  wire logic                                 MCLK_I,
    input  wire logic                                 SYS_RST_I,
    // host port
    hpa_if.device                                     bus,
    // datapath results
    input  wire logic [hpa_pkg::NUM_AGC*hpa_pkg::DW-1:0] AGC_I_I,
    input  wire logic [hpa_pkg::NUM_AGC*hpa_pkg::DW-1:0] AGC_Q_I,
    input  wire logic [hpa_pkg::NUM_AGC-1:0]            AGC_IQ_VLD_I,
    input  wire logic [hpa_pkg::NUM_AGC-1:0]            AGC_EN_I,
    input  wire logic [hpa_pkg::NUM_AGC*hpa_pkg::SW-1:0] SIG_I,
    input  wire logic [hpa_pkg::NUM_AGC-1:0]            SIG_VLD_I,
    // control outputs
    output logic                                      CORE_CLK_EN_O,
    output logic                                      CORE_SETTLED_O,
    output logic                                      FIR_EN_O,
    output logic [7:0]                                OPORT_CFG_O
);
    localparam int CAW = $clog2(COEF_DEPTH);
    typedef enum logic [1:0] {D_IDLE, D_BUSY, D_DONE} hpa_dst_e;

    logic signed [15:0] res_i [hpa_pkg::NUM_AGC];
    logic signed [15:0] res_q [hpa_pkg::NUM_AGC];
    logic signed [11:0] sig   [hpa_pkg::NUM_AGC];
    logic        [15:0] coef  [COEF_DEPTH];
    hpa_dst_e           state;
    hpa_dst_e           next_state;
    logic               hclk_q;
    logic        [1:0]  wcnt;
    logic        [7:0]  clk_cfg;
    logic        [15:0] settle_cnt;
    logic        [CAW-1:0] cptr;
    logic        [CAW-1:0] cstart;
    logic        [CAW-1:0] cstop;
    logic        [4:0]  obud;
    logic        [7:0]  sh;
    logic        [2:0]  bitcnt;
    logic               sbyte;
    logic        [7:0]  s_addr;

    wire rst      = SYS_RST_I | ~bus.rst_n;
    wire hrise    = bus.hclk & ~hclk_q;
    // select low plus rd_n, or either strobe in strobe-pair style; wr_n low marks a write in both styles
    wire acc_req  = !bus.cs_n && (bus.style_ds ? !bus.rd_n : (!bus.rd_n || !bus.wr_n));
    wire is_wr    = !bus.wr_n;
    wire acc_end  = hrise && state == D_BUSY && wcnt == 2'h0;
    wire [7:0] a  = bus.addr;
    wire [15:0] wd_bus = bus.byte_mode ? {8'h00, bus.data[7:0]} : bus.data;
    wire ser_byte = hrise && !bus.serial_select_n && bitcnt == 3'h7;
    wire ser_wr   = ser_byte && sbyte;
    wire par_wr   = acc_end && is_wr;
    wire wr_en    = par_wr | ser_wr;
    wire [7:0]  wa = ser_wr ? s_addr : a;
    wire [15:0] wd = ser_wr ? {8'h00, sh[6:0], bus.sdi} : wd_bus;
    wire coef_acc = acc_end && a == hpa_pkg::OFS_CDATA;
    wire [CAW-1:0] cptr_nx = (cptr == cstop) ? cstart : CAW'(cptr + 1'b1);

    // =========================================
    // read selection
    wire in_i = a < hpa_pkg::OFS_AGC_Q;
    wire in_q = a >= hpa_pkg::OFS_AGC_Q && a < hpa_pkg::OFS_SIG;
    wire in_s = a >= hpa_pkg::OFS_SIG && a < 8'(hpa_pkg::OFS_SIG + hpa_pkg::NUM_AGC);
    wire [2:0] idx_i = a[2:0];
    wire [2:0] idx_q = 3'(a - hpa_pkg::OFS_AGC_Q);
    wire [2:0] idx_s = 3'(a - hpa_pkg::OFS_SIG);
    wire [15:0] coef_rd = FIR_EN_O ? coef[cptr] : 16'h0000;
    wire [15:0] rd_val =
        in_i ? res_i[idx_i] :
        in_q ? res_q[idx_q] :
        in_s ? {{4{sig[idx_s][11]}}, sig[idx_s]} :
        (a == hpa_pkg::OFS_CLK)    ? {8'h00, clk_cfg} :
        (a == hpa_pkg::OFS_STAT)   ? {14'h0000, CORE_SETTLED_O, CORE_CLK_EN_O} :
        (a == hpa_pkg::OFS_FIR)    ? {15'h0000, FIR_EN_O} :
        (a == hpa_pkg::OFS_CSTART) ? 16'(cstart) :
        (a == hpa_pkg::OFS_CSTOP)  ? 16'(cstop) :
        (a == hpa_pkg::OFS_CDATA)  ? coef_rd :
        (a == hpa_pkg::OFS_OCFG)   ? {8'h00, OPORT_CFG_O} :
        (a == hpa_pkg::OFS_OBUD)   ? {11'h000, obud} : 16'h0000;

    // =========================================
    // result capture
    always_ff @(posedge MCLK_I) begin
        for (int k = 0; k < hpa_pkg::NUM_AGC; k++) begin
            if (rst) begin
                res_i[k] <= 16'sh0000;
                res_q[k] <= 16'sh0000;
                sig[k]   <= 12'sh000;
            end else begin
                if (AGC_IQ_VLD_I[k]) begin
                    res_i[k] <= AGC_I_I[k*hpa_pkg::DW +: hpa_pkg::DW];
                    res_q[k] <= AGC_Q_I[k*hpa_pkg::DW +: hpa_pkg::DW];
                end
                if (SIG_VLD_I[k] && AGC_EN_I[k]) begin
                    sig[k] <= SIG_I[k*hpa_pkg::SW +: hpa_pkg::SW];
                end
            end
        end
    end

    // =========================================
    // access sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            D_IDLE: if (hrise && acc_req) next_state = D_BUSY;
            D_BUSY: if (acc_end) next_state = D_DONE;
            D_DONE: if (hrise) next_state = acc_req ? D_BUSY : D_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            state        <= D_IDLE;
            hclk_q       <= 1'b0;
            wcnt         <= 2'h0;
            bus.d_dout   <= 16'h0000;
            bus.d_doe_n  <= 1'b1;
            bus.ack_o    <= 1'b0;
            bus.ack_oe_n <= 1'b1;
        end else begin
            state  <= next_state;
            hclk_q <= bus.hclk;
            if (next_state == D_BUSY && state != D_BUSY) wcnt <= 2'(hpa_pkg::ACC_WAIT - 1);
            else if (hrise && wcnt != 2'h0) wcnt <= wcnt - 2'h1;
            if (acc_end && !is_wr) begin
                bus.d_dout  <= bus.byte_mode ? {8'h00, rd_val[7:0]} : rd_val;
                bus.d_doe_n <= 1'b0;
            end else if (next_state != D_DONE) begin
                bus.d_doe_n <= 1'b1;
            end
            // strobe pair: pending low while busy; data strobe: ack low when done
            bus.ack_oe_n <= bus.style_ds ? (next_state != D_DONE)
                                         : (next_state != D_BUSY);
        end
    end

    // =========================================
    // serial byte receiver, select high realigns the bit count
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            sh     <= 8'h00;
            bitcnt <= 3'h0;
            sbyte  <= 1'b0;
            s_addr <= 8'h00;
        end else if (bus.serial_select_n) begin
            bitcnt <= 3'h0;
        end else if (hrise) begin
            sh     <= {sh[6:0], bus.sdi};
            bitcnt <= bitcnt + 3'h1;
            if (ser_byte) begin
                sbyte <= ~sbyte;
                if (!sbyte) s_addr <= {sh[6:0], bus.sdi};
            end
        end
    end

    // =========================================
    // control registers
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            clk_cfg        <= 8'h00;
            CORE_CLK_EN_O  <= 1'b0;
            CORE_SETTLED_O <= 1'b0;
            settle_cnt     <= 16'h0000;
            FIR_EN_O       <= 1'b0;
            cptr           <= '0;
            cstart         <= '0;
            cstop          <= '0;
            OPORT_CFG_O    <= 8'h00;
            obud           <= 5'(hpa_pkg::FRAME_OVH);
        end else begin
            if (wr_en && wa == hpa_pkg::OFS_CLK) begin
                clk_cfg        <= wd[7:0];
                CORE_CLK_EN_O  <= |wd[7:0];
                CORE_SETTLED_O <= 1'b0;
                settle_cnt     <= 16'h0000;
            end else if (CORE_CLK_EN_O && !CORE_SETTLED_O) begin
                settle_cnt     <= settle_cnt + 16'h0001;
                CORE_SETTLED_O <= settle_cnt == 16'(SETTLE_CYCLES - 1);
            end
            if (wr_en && wa == hpa_pkg::OFS_FIR) FIR_EN_O <= wd[0];
            if (wr_en && wa == hpa_pkg::OFS_CSTOP) cstop <= wd[CAW-1:0];
            if (wr_en && wa == hpa_pkg::OFS_CSTART) begin
                cstart <= wd[CAW-1:0];
                cptr   <= wd[CAW-1:0];
            end else if (coef_acc || (ser_wr && wa == hpa_pkg::OFS_CDATA)) begin
                cptr <= cptr_nx;
            end
            if (wr_en && wa == hpa_pkg::OFS_OCFG) OPORT_CFG_O <= wd[7:0];
            obud <= hpa_pkg::frame_budget(OPORT_CFG_O);
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (wr_en && wa == hpa_pkg::OFS_CDATA && FIR_EN_O) coef[cptr] <= wd;
    end
endmodule : hpa_dev

// >>> design/hpa_host.sv
`timescale 1ns/100ps
module hpa_host #(
    parameter int HCLK_DIV      = 4,
    parameter int SETTLE_CYCLES = hpa_pkg::SETTLE_CYC
) (
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        SYS_RST_I,
    // command port
    input  wire logic [2:0]  REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [15:0] REG_RDATA_O,
    // device port
    hpa_if.host              bus
);
    typedef enum logic [2:0] {H_RST, H_IDLE, H_HOLD, H_PAR, H_REL, H_SER} hpa_hst_e;

    hpa_hst_e    state;
    logic [7:0]  addr_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic [1:0]  go_r;
    logic [7:0]  hcnt;
    logic [3:0]  rcnt;
    logic [15:0] settle_cnt;
    logic        settled;
    logic        seen_low;
    logic [15:0] sh;
    logic [3:0]  bits;
    logic        nbyte;

    // divide by at least three keeps the port clock under the limit
    localparam int DIV = (HCLK_DIV < hpa_pkg::HCLK_DIV_MIN) ? hpa_pkg::HCLK_DIV_MIN
                                                             : HCLK_DIV;
    wire hfall  = hcnt == 8'(DIV / 2);
    wire hwrap  = hcnt == 8'(DIV - 1);
    wire guard  = addr_r >= hpa_pkg::GUARD_LO && addr_r <= hpa_pkg::GUARD_HI;
    wire go     = REG_WR_I && REG_ADDR_I == hpa_pkg::H_GO && state == H_IDLE;
    wire done_p = bus.style_ds ? !bus.ack : (seen_low && bus.ack);
    wire [15:0] stat = {13'h0000, settled, state != H_IDLE, state != H_RST};

    // =========================================
    // port clock and command registers
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            hcnt          <= 8'h00;
            bus.hclk      <= 1'b0;
            addr_r        <= 8'h00;
            wdata_r       <= 16'h0000;
            bus.style_ds  <= 1'b0;
            bus.byte_mode <= 1'b0;
            REG_RDATA_O   <= 16'h0000;
        end else begin
            hcnt     <= hwrap ? 8'h00 : hcnt + 8'h01;
            bus.hclk <= hwrap || hcnt < 8'(DIV / 2 - 1);
            if (REG_WR_I && REG_ADDR_I == hpa_pkg::H_ADDR) addr_r <= REG_WDATA_I[7:0];
            if (REG_WR_I && REG_ADDR_I == hpa_pkg::H_WDATA) wdata_r <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == hpa_pkg::H_MODE) begin
                bus.style_ds  <= REG_WDATA_I[hpa_pkg::MODE_DS];
                bus.byte_mode <= REG_WDATA_I[hpa_pkg::MODE_BYTE];
            end
            if (REG_RD_I) begin
                REG_RDATA_O <= (REG_ADDR_I == hpa_pkg::H_ADDR)  ? {8'h00, addr_r} :
                               (REG_ADDR_I == hpa_pkg::H_WDATA) ? wdata_r :
                               (REG_ADDR_I == hpa_pkg::H_STAT)  ? stat :
                               (REG_ADDR_I == hpa_pkg::H_RDATA) ? rdata_r :
                               (REG_ADDR_I == hpa_pkg::H_MODE)  ?
                               {14'h0000, bus.byte_mode, bus.style_ds} : 16'h0000;
            end
        end
    end

    // =========================================
    // access sequencer
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            state               <= H_RST;
            rcnt                <= 4'h0;
            bus.rst_n           <= 1'b0;
            go_r                <= 2'h0;
            rdata_r             <= 16'h0000;
            settle_cnt          <= 16'h0000;
            settled             <= 1'b0;
            seen_low            <= 1'b0;
            bus.cs_n            <= 1'b1;
            bus.rd_n            <= 1'b1;
            bus.wr_n            <= 1'b1;
            bus.addr            <= 8'h00;
            bus.h_dout          <= 16'h0000;
            bus.h_doe_n         <= 1'b1;
            bus.serial_select_n <= 1'b1;
            bus.sdi             <= 1'b0;
            sh                  <= 16'h0000;
            bits                <= 4'h0;
            nbyte               <= 1'b0;
        end else begin
            if (settle_cnt != 16'h0000) begin
                settle_cnt <= settle_cnt - 16'h0001;
                settled    <= settle_cnt == 16'h0001;
            end
            unique case (state)
                H_RST: begin
                    rcnt <= rcnt + 4'h1;
                    if (rcnt == 4'(hpa_pkg::RST_CYC)) begin
                        bus.rst_n <= 1'b1;
                        state     <= H_IDLE;
                    end
                end
                H_IDLE: if (go) begin
                    go_r  <= REG_WDATA_I[1:0];
                    state <= H_HOLD;
                end
                H_HOLD: if (hfall && (!guard || settled)) begin
                    if (!go_r[hpa_pkg::GO_RD] && addr_r == hpa_pkg::OFS_CLK) begin
                        settle_cnt <= 16'(SETTLE_CYCLES);
                        settled    <= 1'b0;
                    end
                    if (go_r[hpa_pkg::GO_SER]) begin
                        sh    <= {addr_r, wdata_r[7:0]};
                        bits  <= 4'h0;
                        nbyte <= 1'b0;
                        state <= H_SER;
                    end else begin
                        bus.cs_n    <= 1'b0;
                        bus.rd_n    <= bus.style_ds ? 1'b0 : !go_r[hpa_pkg::GO_RD];
                        bus.wr_n    <= go_r[hpa_pkg::GO_RD];
                        bus.addr    <= addr_r;
                        bus.h_dout  <= bus.byte_mode ? {8'h00, wdata_r[7:0]} : wdata_r;
                        bus.h_doe_n <= go_r[hpa_pkg::GO_RD];
                        seen_low    <= 1'b0;
                        state       <= H_PAR;
                    end
                end
                H_PAR: begin
                    if (!bus.ack) seen_low <= 1'b1;
                    // strobes stay until completion, then drop so no repeat starts
                    if (done_p) begin
                        if (go_r[hpa_pkg::GO_RD]) rdata_r <= bus.data;
                        bus.cs_n    <= 1'b1;
                        bus.rd_n    <= 1'b1;
                        bus.wr_n    <= 1'b1;
                        bus.h_doe_n <= 1'b1;
                        state       <= H_REL;
                    end
                end
                H_REL: if (hwrap && bus.ack) state <= H_IDLE;
                H_SER: if (hfall) begin
                    if (bits == 4'h8) begin
                        bus.serial_select_n <= 1'b1;
                        bits                <= 4'h0;
                        nbyte               <= 1'b1;
                        if (nbyte) state <= H_REL;
                    end else begin
                        bus.serial_select_n <= 1'b0;
                        bus.sdi             <= sh[15];
                        sh                  <= {sh[14:0], 1'b0};
                        bits                <= bits + 4'h1;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule : hpa_host

// >>> verif/hpa_assertions.sv
`timescale 1ns/100ps
// =========================================
// port handshake checks, both bus styles
module hpa_assertions (
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        SYS_RST_I,
    // port signals
    input  wire logic        rst_n,
    input  wire logic        hclk,
    input  wire logic        style_ds,
    input  wire logic        byte_mode,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] data,
    input  wire logic        d_doe_n,
    input  wire logic        ack_o,
    input  wire logic        ack_oe_n
);
    logic       hclk_q;
    logic [1:0] acc_hr;
    // port clock edge as the device sees it
    wire  hr   = hclk & ~hclk_q;
    // only an idle port starts; the later edges of an access are no start
    wire  go_p = hr & ~cs_n & (~rd_n | (~wr_n & ~style_ds)) & ack_oe_n & (acc_hr == 2'h0);

    always_ff @(posedge MCLK_I) begin
        hclk_q <= hclk;
        if (SYS_RST_I || !rst_n) begin
            acc_hr <= 2'h0;
        end else if (go_p) begin
            acc_hr <= 2'(hpa_pkg::ACC_WAIT);
        end else if (hr && acc_hr != 2'h0) begin
            acc_hr <= acc_hr - 2'h1;
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I || !rst_n);

    // =========================================
    // access steps
    sequence pend_s;
        !ack_oe_n [*4] ##[1:20] ack_oe_n;
    endsequence
    sequence ds_s;
        ack_oe_n [*4] ##[1:12] !ack_oe_n;
    endsequence

    pend_low_a: assert property (go_p && !style_ds |-> ##[1:2] !ack_oe_n)
        else $error("pending not low after start");
    pend_hold_a: assert property ($fell(ack_oe_n) && !style_ds |-> pend_s)
        else $error("pending released early or never");
    ds_ack_a: assert property (go_p && style_ds |=> ds_s)
        else $error("acknowledge early or missing");
    ack_zero_a: assert property (ack_o == 1'b0)
        else $error("open drain pin driven high");
    rd_data_a: assert property ($rose(ack_oe_n) && !style_ds && !rd_n |-> !d_doe_n)
        else $error("read done without data");
    wr_quiet_a: assert property (!cs_n && !wr_n |-> d_doe_n)
        else $error("device drives bus during write");
    byte_hi_a: assert property (!d_doe_n && byte_mode |-> data[15:8] == 8'h00)
        else $error("upper lanes driven in byte mode");
    release_a: assert property (hr && cs_n |=> ack_oe_n && d_doe_n)
        else $error("pins held after deselect");
endmodule : hpa_assertions

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
    logic        mclk, rst, wr, rd, cken, stl, firen;
    logic [2:0]  ra;
    logic [15:0] rw, rdat, rdv;
    logic [95:0] ai, aq;
    logic [71:0] sg;
    logic [5:0]  avld, aen, svld;
    logic [7:0]  ocfg;
    logic [3:0]  cyc [4] = '{4'h3, 4'h2, 4'h2, 4'h1};
    int          bad_count, checked, k;
    hpa_if hb ();
    hpa_dev #(.SETTLE_CYCLES(20)) hpa_dev_i (.MCLK_I(mclk), .SYS_RST_I(rst), .bus(hb.device),
        .AGC_I_I(ai), .AGC_Q_I(aq), .AGC_IQ_VLD_I(avld), .AGC_EN_I(aen), .SIG_I(sg),
        .SIG_VLD_I(svld), .CORE_CLK_EN_O(cken), .CORE_SETTLED_O(stl), .FIR_EN_O(firen),
        .OPORT_CFG_O(ocfg));
    hpa_host #(.SETTLE_CYCLES(20)) hpa_host_i (.MCLK_I(mclk), .SYS_RST_I(rst), .REG_ADDR_I(ra),
        .REG_WDATA_I(rw), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .bus(hb.host));
    hpa_assertions hpa_assertions_i (.MCLK_I(mclk), .SYS_RST_I(rst), .rst_n(hb.rst_n),
        .hclk(hb.hclk), .style_ds(hb.style_ds), .byte_mode(hb.byte_mode), .cs_n(hb.cs_n),
        .rd_n(hb.rd_n), .wr_n(hb.wr_n), .data(hb.data), .d_doe_n(hb.d_doe_n),
        .ack_o(hb.ack_o), .ack_oe_n(hb.ack_oe_n));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task results;
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        ra <= a;
        rw <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [2:0] a);
        @(posedge mclk);
        ra <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        rdv = rdat;
    endtask : rreg
    // bounded poll of one status bit; a hang ends the run
    task poll(input int b, input logic v);
        int n;
        for (n = 0; n < 300; n++) begin
            rreg(hpa_pkg::H_STAT);
            if (rdv[b] === v) break;
        end
        if (n == 300) begin
            bad_count++;
            results();
        end
    endtask : poll
    task acc(input logic [7:0] a, input logic [15:0] d, input logic [1:0] go);
        wreg(hpa_pkg::H_ADDR, {8'h00, a});
        wreg(hpa_pkg::H_WDATA, d);
        wreg(hpa_pkg::H_GO, {14'h0000, go});
        poll(1, 1'b0);
        rreg(hpa_pkg::H_RDATA);
    endtask : acc

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        rst = 1'b1;
        {ra, rw, wr, rd, ai, aq, avld, aen, sg, svld} = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        poll(0, 1'b1);
        chk({15'h0000, cken}, 16'h0000);
        // distinct negative samples per stage catch address slips
        for (k = 0; k < 6; k++) begin
            ai[16*k +: 16] <= 16'h8001 + 16'(k) * 16'h1010;
            aq[16*k +: 16] <= 16'hF00F - 16'(k) * 16'h0101;
            sg[12*k +: 12] <= 12'h801 + 12'(k) * 12'h011;
        end
        aen  <= 6'h15;
        avld <= 6'h3F;
        svld <= 6'h3F;
        @(posedge mclk);
        {avld, svld} <= 12'h000;
        for (k = 0; k < 6; k++) begin
            acc(hpa_pkg::OFS_AGC_I + 8'(k), 16'h0000, 2'h1);
            chk(rdv, ai[16*k +: 16]);
            acc(hpa_pkg::OFS_AGC_Q + 8'(k), 16'h0000, 2'h1);
            chk(rdv, aq[16*k +: 16]);
            acc(hpa_pkg::OFS_SIG + 8'(k), 16'h0000, 2'h1);
            chk(rdv, aen[k] ? {{4{sg[12*k+11]}}, sg[12*k +: 12]} : 16'h0000);
        end
        acc(hpa_pkg::OFS_AGC_I, 16'h0000, 2'h1);
        chk(rdv, ai[15:0]);
        for (k = 0; k < 4; k++) begin
            wreg(hpa_pkg::H_MODE, 16'(k));
            acc(hpa_pkg::OFS_AGC_I + 8'h01, 16'h0000, 2'h1);
            chk(rdv, k[1] ? {8'h00, ai[23:16]} : ai[31:16]);
        end
        wreg(hpa_pkg::H_MODE, 16'h0000);
        acc(hpa_pkg::OFS_STAT, 16'h0000, 2'h1);
        chk(rdv, 16'h0000);
        acc(hpa_pkg::OFS_CLK, 16'h0005, 2'h0);
        chk({15'h0000, cken}, 16'h0001);
        poll(2, 1'b1);
        for (k = 0; k < 4; k++) begin
            acc(hpa_pkg::OFS_OCFG, {8'h00, 2'(k), 6'h3F >> k}, 2'h0);
            acc(hpa_pkg::OFS_OBUD, 16'h0000, 2'h1);
            chk(rdv, 16'(1 + (6 - k) * cyc[k]));
        end
        acc(hpa_pkg::OFS_CSTART, 16'h0003, 2'h0);
        acc(hpa_pkg::OFS_CSTOP, 16'h0003, 2'h0);
        acc(hpa_pkg::OFS_CDATA, 16'h5A5A, 2'h0);
        acc(hpa_pkg::OFS_CDATA, 16'h0000, 2'h1);
        chk(rdv, 16'h0000);
        acc(hpa_pkg::OFS_FIR, 16'h0001, 2'h2);
        chk({15'h0000, firen}, 16'h0001);
        acc(hpa_pkg::OFS_CDATA, 16'hA5C3, 2'h0);
        acc(hpa_pkg::OFS_CDATA, 16'h0000, 2'h1);
        chk(rdv, 16'hA5C3);
        // two-word window: each data access steps the pointer, then wraps
        acc(hpa_pkg::OFS_CSTART, 16'h0002, 2'h0);
        acc(hpa_pkg::OFS_CDATA, 16'h1234, 2'h0);
        acc(hpa_pkg::OFS_CDATA, 16'h0000, 2'h1);
        chk(rdv, 16'hA5C3);
        acc(hpa_pkg::OFS_CDATA, 16'h0000, 2'h1);
        chk(rdv, 16'h1234);
        results();
    end
endmodule : tb
